/* rtl/sdd_device.sv */
// Purpose: four-digit static seven-segment decoder, latch and backplane driver
// Assumes: link pins are asynchronous to hclk and pass two flip-flops
// Notes: variant chosen by parameters; analog drive is not modelled
//        selects and their history reset high, so leaving reset commits nothing
//        segments settle three cycles after a slave backplane edge on the pin
`timescale 1ns/1ps
module sdd_device #(
    parameter bit LCD_VARIANT = 1'b1,
    parameter bit HEX_DECODE = 1'b1,
    parameter bit MPU_VARIANT = 1'b0,
    parameter int unsigned OSC_DIV_CYCLES = sdd_pkg::OSC_DIV_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // link to the controlling party
    sdd_link_if.device link,
    // display side
    output logic [27:0] segment,
    output logic backplane_master
);
    localparam int unsigned PIN_W = 15;
    // bit positions inside the two-flop sampler
    localparam int unsigned P_DATA = 0;
    localparam int unsigned P_STROBE = 4;
    localparam int unsigned P_ADDR = 8;
    localparam int unsigned P_CS2 = 10;
    localparam int unsigned P_CS1 = 11;
    localparam int unsigned P_BRIGHT = 12;
    localparam int unsigned P_BP = 13;
    localparam int unsigned P_OSC = 14;

    if (OSC_DIV_CYCLES < 2 || OSC_DIV_CYCLES >= (1 << sdd_pkg::CNT_W)) begin : g_chk
        $error("oscillator divider out of range");
    end

    // the phase counter is six bits, so only a division of 128 fits
    if (sdd_pkg::BP_HALF != 64) begin : g_chk_bp
        $error("backplane phase counter does not match the division");
    end

    // the filter counter is nine bits and must reach the disable count
    if (sdd_pkg::OSC_LOW_CYC >= 512) begin : g_chk_low
        $error("disable filter count does not fit its counter");
    end

    if (P_OSC != PIN_W - 1) begin : g_chk_pins
        $error("sampler width does not match its fields");
    end

    typedef struct packed {
        logic [PIN_W-1:0] sync1;
        logic [PIN_W-1:0] sync2;
        logic [sdd_pkg::CNT_W-1:0] osc_cnt;
        logic [5:0] bp_phase;
        logic bp_int;
        logic [8:0] low_cnt;
        logic bp_disabled;
        logic [3:0] in_data;
        logic [1:0] in_addr;
        logic in_loaded;
        logic cs1_prev;
        logic cs2_prev;
        logic [3:0][6:0] lit;
        logic [27:0] seg;
    } sdd_dev_state_t;

    sdd_dev_state_t q;
    sdd_dev_state_t d;
    logic [3:0] s_data;
    logic [3:0] s_strobe;
    logic [1:0] s_addr;
    logic s_cs1n;
    logic s_cs2n;
    logic s_bright;
    logic s_bp;
    logic s_osc_low;
    logic bp_ref;
    logic osc_tick;
    logic [1:0] target;
    logic sel_both_low;
    logic sel_rise;

    always_comb begin
        d = q;
        // only the second stage is read by logic
        d.sync1[P_DATA +: 4] = link.data_bits;
        d.sync1[P_STROBE +: 4] = link.digit_strobe;
        d.sync1[P_ADDR +: 2] = link.digit_address;
        d.sync1[P_CS2] = link.chip_select_n_second;
        d.sync1[P_CS1] = link.chip_select_n_first;
        d.sync1[P_BRIGHT] = link.brightness;
        d.sync1[P_BP] = link.backplane_terminal;
        d.sync1[P_OSC] = link.osc_drive_low;
        d.sync2 = q.sync1;
        s_data = q.sync2[P_DATA +: 4];
        s_strobe = q.sync2[P_STROBE +: 4];
        s_addr = q.sync2[P_ADDR +: 2];
        s_cs2n = q.sync2[P_CS2];
        s_cs1n = q.sync2[P_CS1];
        s_bright = q.sync2[P_BRIGHT];
        s_bp = q.sync2[P_BP];
        s_osc_low = q.sync2[P_OSC];
        sel_both_low = !s_cs1n && !s_cs2n;
        // a rise of either select ends the write, both together still once
        sel_rise = (s_cs1n && !q.cs1_prev) || (s_cs2n && !q.cs2_prev);
        osc_tick = 1'b0;
        target = ~q.in_addr;

        // free-running oscillator, stopped while the pin is held low
        if (!s_osc_low) begin
            if (q.osc_cnt == sdd_pkg::CNT_W'(OSC_DIV_CYCLES - 1)) begin
                d.osc_cnt = '0;
                osc_tick = 1'b1;
            end else begin
                d.osc_cnt = q.osc_cnt + 1'b1;
            end
        end
        if (osc_tick) begin
            d.bp_phase = q.bp_phase + 1'b1;
            if (q.bp_phase == 6'(sdd_pkg::BP_HALF - 1)) begin
                d.bp_int = ~q.bp_int;
            end
        end

        // a skewed overdrive low must not disable the driver
        // the count holds at its limit, so a stuck low keeps the driver off
        if (s_osc_low) begin
            if (q.low_cnt < 9'(sdd_pkg::OSC_LOW_CYC)) begin
                d.low_cnt = q.low_cnt + 1'b1;
            end else begin
                d.bp_disabled = 1'b1;
            end
        end else begin
            d.low_cnt = '0;
            d.bp_disabled = 1'b0;
        end

        if (MPU_VARIANT) begin
            d.cs1_prev = s_cs1n;
            d.cs2_prev = s_cs2n;
            // the input latch is transparent only while both selects are low
            if (sel_both_low) begin
                d.in_data = s_data;
                d.in_addr = s_addr;
                d.in_loaded = 1'b1;
            end
            // a rise with no write before it leaves the digits alone
            if (q.in_loaded && sel_rise) begin
                d.lit[target] = sdd_pkg::sdd_decode(q.in_data, HEX_DECODE);
                d.in_loaded = 1'b0;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (s_strobe[i]) begin
                    d.lit[i] = sdd_pkg::sdd_decode(s_data, HEX_DECODE);
                end
            end
        end

        // slave follows the terminal, master its own divider
        bp_ref = q.bp_disabled ? s_bp : q.bp_int;
        if (LCD_VARIANT) begin
            // equal phase on pin and backplane keeps dc off the glass
            d.seg = q.lit ^ {28{bp_ref}};
        end else begin
            // a plain gate, so a duty cycle on the pin dims the display
            d.seg = q.lit & {28{s_bright}};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            // selects idle high; a low history would fake a write on release
            q.sync1[P_CS1] <= 1'b1;
            q.sync1[P_CS2] <= 1'b1;
            q.sync2[P_CS1] <= 1'b1;
            q.sync2[P_CS2] <= 1'b1;
            q.cs1_prev <= 1'b1;
            q.cs2_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign segment = q.seg;
    assign backplane_master = LCD_VARIANT & ~q.bp_disabled;
    assign link.bp_dev_out = q.bp_int;
    assign link.bp_dev_oe = LCD_VARIANT & ~q.bp_disabled;
endmodule : sdd_device

/* rtl/sdd_pkg.sv */
// Purpose: shared constants, decode tables and types of the segment decoder pair
// Assumes: hclk at 250 MHz
// Notes: segment bit 0 is a, bit 6 is g; digit one sits in the low seven bits
package sdd_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned CLK_NS = 4;
    localparam int unsigned CNT_W = 24;
    // internal oscillator and backplane division
    localparam int unsigned OSC_HZ = 19_000;
    localparam int unsigned OSC_DIV_CYC = CLK_HZ / OSC_HZ;
    localparam int unsigned BP_DIV = 128;
    localparam int unsigned BP_HALF = BP_DIV / 2;
    // backplane disable sensing
    localparam int unsigned OSC_LOW_NS = 1000;
    localparam int unsigned OSC_LOW_CYC = (OSC_LOW_NS + CLK_NS - 1) / CLK_NS;
    // host write timing
    localparam int unsigned MUX_SETUP_NS = 500;
    localparam int unsigned MUX_WIDTH_NS = 1000;
    localparam int unsigned MUX_HOLD_NS = 200;
    localparam int unsigned CS_SETUP_NS = 100;
    localparam int unsigned CS_WIDTH_NS = 200;
    localparam int unsigned CS_HOLD_NS = 10;
    localparam int unsigned GAP_NS = 2000;
    localparam int unsigned MUX_SETUP_CYC = (MUX_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned MUX_WIDTH_CYC = (MUX_WIDTH_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned MUX_HOLD_CYC = (MUX_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CS_SETUP_CYC = (CS_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CS_WIDTH_CYC = (CS_WIDTH_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CS_HOLD_CYC = (CS_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
    // external backplane: half period rounded up keeps the rate at or below the limit
    localparam int unsigned EXT_BP_HZ = 150;
    localparam int unsigned EXT_BP_HALF_CYC = (CLK_HZ + 2 * EXT_BP_HZ - 1) / (2 * EXT_BP_HZ);
    // host register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_WRITE = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int unsigned CTRL_MPU_BIT = 0;
    localparam int unsigned CTRL_SLAVE_BIT = 1;
    localparam int unsigned CTRL_EXTBP_BIT = 2;
    localparam int unsigned CTRL_BFULL_BIT = 3;
    localparam int unsigned CTRL_DUTY_LSB = 8;
    localparam int unsigned WR_DATA_LSB = 0;
    localparam int unsigned WR_DIGIT_LSB = 4;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [1:0] HSIZE_WORD_LOW = 2'h2;
    // decode tables, entry 15 first
    localparam logic [15:0][6:0] HEX_TABLE = {
        7'h71, 7'h79, 7'h5e, 7'h39, 7'h7c, 7'h77, 7'h6f, 7'h7f,
        7'h07, 7'h7d, 7'h6d, 7'h66, 7'h4f, 7'h5b, 7'h06, 7'h3f};
    localparam logic [15:0][6:0] CODEB_TABLE = {
        7'h00, 7'h73, 7'h38, 7'h76, 7'h79, 7'h40, 7'h6f, 7'h7f,
        7'h07, 7'h7d, 7'h6d, 7'h66, 7'h4f, 7'h5b, 7'h06, 7'h3f};

    typedef enum logic [2:0] {
        SDD_IDLE = 3'b000,
        SDD_SETUP = 3'b001,
        SDD_ACTIVE = 3'b010,
        SDD_HOLD = 3'b011,
        SDD_GAP = 3'b100
    } sdd_hstate_t;

    function automatic logic [6:0] sdd_decode(input logic [3:0] code, input logic hex);
        sdd_decode = hex ? HEX_TABLE[code] : CODEB_TABLE[code];
    endfunction : sdd_decode
endpackage : sdd_pkg

/* rtl/sdd_link_if.sv */
// Purpose: pins between the controlling party and the segment decoder
// Assumes: both ends on hclk
// Notes: backplane wire resolves from the two enables, low when undriven
`timescale 1ns/1ps
interface sdd_link_if;
    logic [3:0] data_bits;
    logic [3:0] digit_strobe;
    logic [1:0] digit_address;
    logic chip_select_n_first;
    logic chip_select_n_second;
    logic osc_drive_low;
    logic brightness;
    logic bp_dev_out;
    logic bp_dev_oe;
    logic bp_host_out;
    logic bp_host_oe;
    logic backplane_terminal;

    assign backplane_terminal = bp_dev_oe ? bp_dev_out : (bp_host_oe & bp_host_out);

    modport device (
        input data_bits, digit_strobe, digit_address, chip_select_n_first,
        chip_select_n_second, osc_drive_low, brightness, backplane_terminal,
        output bp_dev_out, bp_dev_oe
    );
    modport host (
        output data_bits, digit_strobe, digit_address, chip_select_n_first,
        chip_select_n_second, osc_drive_low, brightness, bp_host_out, bp_host_oe,
        input backplane_terminal
    );
endinterface : sdd_link_if

/* rtl/sdd_host.sv */
// Purpose: controlling party: writes digits over the link under AHB-Lite control
// Assumes: single word transfers, zero wait states
// Notes: a write order while busy is dropped; poll the busy bit first
`timescale 1ns/1ps
module sdd_host #(
    parameter int unsigned EXT_BP_HALF_CYCLES = sdd_pkg::EXT_BP_HALF_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // link to the decoder
    sdd_link_if.host link
);
    if (EXT_BP_HALF_CYCLES < 2 || EXT_BP_HALF_CYCLES >= (1 << sdd_pkg::CNT_W)) begin : g_chk
        $error("external backplane divider out of range");
    end

    typedef struct packed {
        sdd_pkg::sdd_hstate_t st;
        logic [9:0] cnt;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic [31:0] ctrl;
        logic [3:0] req_data;
        logic [1:0] req_digit;
        logic [sdd_pkg::CNT_W-1:0] bp_cnt;
        logic bp;
        logic [7:0] pwm;
        logic bright;
        logic [3:0] data_o;
        logic [3:0] strobe_o;
        logic [1:0] addr_o;
        logic csn_o;
    } sdd_host_state_t;

    sdd_host_state_t q;
    sdd_host_state_t d;
    logic mpu;
    logic busy;

    always_comb begin
        d = q;
        mpu = q.ctrl[sdd_pkg::CTRL_MPU_BIT];
        busy = (q.st != sdd_pkg::SDD_IDLE);

        // address phase: decode and register read data
        d.wr_pend = 1'b0;
        if (hsel && htrans[1] && hready) begin
            d.wr_pend = hwrite && (hsize[1:0] == sdd_pkg::HSIZE_WORD_LOW);
            d.wr_addr = haddr[7:0];
            if (!hwrite) begin
                unique case (haddr[7:0])
                    sdd_pkg::REG_CTRL: d.rdata = q.ctrl;
                    sdd_pkg::REG_STATUS: d.rdata = {31'h0000_0000, busy};
                    default: d.rdata = 32'h0000_0000;
                endcase
            end
        end
        // data phase
        if (q.wr_pend) begin
            if (q.wr_addr == sdd_pkg::REG_CTRL) begin
                d.ctrl = hwdata;
            end else if (q.wr_addr == sdd_pkg::REG_WRITE && !busy) begin
                d.req_data = hwdata[sdd_pkg::WR_DATA_LSB +: 4];
                d.req_digit = hwdata[sdd_pkg::WR_DIGIT_LSB +: 2];
                d.st = sdd_pkg::SDD_SETUP;
                d.cnt = mpu ? 10'(sdd_pkg::CS_SETUP_CYC - 1) : 10'(sdd_pkg::MUX_SETUP_CYC - 1);
            end
        end

        // write sequence on the pins
        if (busy && q.cnt != '0) begin
            d.cnt = q.cnt - 1'b1;
        end
        unique case (q.st)
            sdd_pkg::SDD_IDLE: begin
                d.strobe_o = '0;
                d.csn_o = 1'b1;
            end
            sdd_pkg::SDD_SETUP: begin
                d.data_o = q.req_data;
                d.addr_o = q.req_digit;
                if (q.cnt == '0) begin
                    d.st = sdd_pkg::SDD_ACTIVE;
                    d.cnt = mpu ? 10'(sdd_pkg::CS_WIDTH_CYC - 1) : 10'(sdd_pkg::MUX_WIDTH_CYC - 1);
                    d.csn_o = ~mpu;
                    d.strobe_o = mpu ? 4'h0 : (4'h1 << q.req_digit);
                end
            end
            sdd_pkg::SDD_ACTIVE: begin
                if (q.cnt == '0) begin
                    d.st = sdd_pkg::SDD_HOLD;
                    d.cnt = mpu ? 10'(sdd_pkg::CS_HOLD_CYC - 1) : 10'(sdd_pkg::MUX_HOLD_CYC - 1);
                    d.csn_o = 1'b1;
                    d.strobe_o = '0;
                end
            end
            sdd_pkg::SDD_HOLD: begin
                if (q.cnt == '0) begin
                    d.st = sdd_pkg::SDD_GAP;
                    d.cnt = 10'(sdd_pkg::GAP_CYC - 1);
                end
            end
            sdd_pkg::SDD_GAP: begin
                if (q.cnt == '0) begin
                    d.st = sdd_pkg::SDD_IDLE;
                end
            end
            default: d.st = sdd_pkg::SDD_IDLE;
        endcase

        // shared external backplane for slaved decoders
        if (q.bp_cnt == sdd_pkg::CNT_W'(EXT_BP_HALF_CYCLES - 1)) begin
            d.bp_cnt = '0;
            d.bp = ~q.bp;
        end else begin
            d.bp_cnt = q.bp_cnt + 1'b1;
        end

        // brightness by duty cycle, or forced on
        d.pwm = q.pwm + 1'b1;
        d.bright = q.ctrl[sdd_pkg::CTRL_BFULL_BIT] ||
                   (q.pwm < q.ctrl[sdd_pkg::CTRL_DUTY_LSB +: 8]);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.ctrl <= sdd_pkg::CTRL_RESET;
            q.csn_o <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign link.data_bits = q.data_o;
    assign link.digit_strobe = q.strobe_o;
    assign link.digit_address = q.addr_o;
    assign link.chip_select_n_first = q.csn_o;
    assign link.chip_select_n_second = q.csn_o;
    assign link.osc_drive_low = q.ctrl[sdd_pkg::CTRL_SLAVE_BIT];
    assign link.brightness = q.bright;
    assign link.bp_host_out = q.bp;
    assign link.bp_host_oe = q.ctrl[sdd_pkg::CTRL_SLAVE_BIT] & q.ctrl[sdd_pkg::CTRL_EXTBP_BIT];
endmodule : sdd_host

/* test/sdd_link_checker.sv */
// Purpose: link checks beside the processor-mode LCD pair
// Assumes: device built with OSC_DIV_CYCLES of 4, so a backplane half is 256 hclk
// Notes: counters saturate so long idle stretches never wrap into false hits
`timescale 1ns/1ps
module sdd_link_checker (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // link pins
    input wire logic [3:0] data_bits,
    input wire logic [1:0] digit_address,
    input wire logic chip_select_n_first,
    input wire logic chip_select_n_second,
    input wire logic osc_drive_low,
    input wire logic bp_dev_out,
    input wire logic bp_dev_oe
);
    logic [9:0] low_q;
    logic [9:0] cs_q;
    logic [9:0] gap_q;
    logic [9:0] half_q;
    logic seen_q;
    logic bp_prev_q;
    logic tog;

    assign tog = bp_dev_out != bp_prev_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_q <= 10'h000;
            cs_q <= 10'h000;
            gap_q <= 10'h3ff;
            half_q <= 10'h000;
            seen_q <= 1'b0;
            bp_prev_q <= 1'b0;
        end else begin
            low_q <= !osc_drive_low ? 10'h000 : ((low_q == 10'h3ff) ? low_q : low_q + 10'h001);
            cs_q <= chip_select_n_first ? 10'h000 : ((cs_q == 10'h3ff) ? cs_q : cs_q + 10'h001);
            gap_q <= !chip_select_n_first ? 10'h000 : ((gap_q == 10'h3ff) ? gap_q : gap_q + 10'h001);
            half_q <= tog ? 10'h001 : ((half_q == 10'h3ff) ? half_q : half_q + 10'h001);
            // a stopped oscillator breaks the half period, so disarm until a clean toggle
            seen_q <= (tog | seen_q) & bp_dev_oe & !osc_drive_low;
            bp_prev_q <= bp_dev_out;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_bp_half_period: assert property ((tog && seen_q) |-> half_q == 10'h100)
        else $error("backplane half period is not 128 oscillator ticks over two");
    a_bp_short_low: assert property ((osc_drive_low && low_q < 10'h0f0) |-> bp_dev_oe)
        else $error("backplane drive dropped on a short oscillator low");
    a_bp_disable_long: assert property (low_q == 10'h12c |-> !bp_dev_oe)
        else $error("backplane drive still on after a long oscillator low");
    a_bp_reenable: assert property ($fell(osc_drive_low) |-> ##[1:6] bp_dev_oe)
        else $error("backplane drive not restored after oscillator release");
    a_cs_width: assert property ($rose(chip_select_n_first) |-> cs_q >= 10'h032)
        else $error("chip select low pulse shorter than 200 ns");
    a_cs_together: assert property (chip_select_n_first == chip_select_n_second)
        else $error("chip selects not driven together");
    a_cs_data_stable: assert property ((!chip_select_n_first && !chip_select_n_second)
        |-> $stable(data_bits) && $stable(digit_address))
        else $error("data or address moved while both selects low");
    a_cs_spacing: assert property ($fell(chip_select_n_first) |-> gap_q >= 10'h1f4)
        else $error("writes closer than 2 us");

    c_write: cover property ($rose(chip_select_n_first));
    c_slave: cover property (!bp_dev_oe);
    c_half: cover property (tog && seen_q);
endmodule : sdd_link_checker

/* test/four_digit_segment_decoder_driver_tb.sv */
// Purpose: pair A is LCD hex processor mode, pair B is LED code B multiplexed
// Assumes: short oscillator division and external backplane half periods
// Notes: expected segments come from the bench's own tables and digit model
`timescale 1ns/1ps
module four_digit_segment_decoder_driver_tb;
    logic hclk;
    logic hresetn;
    logic hsel_a;
    logic hsel_b;
    logic bsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic ro_a, ro_b, resp_a, resp_b, bpm_a, bpm_b;
    logic [31:0] rd_a, rd_b;
    logic [27:0] seg_a, seg_b;
    int miscompares;
    int n_checks;
    int code_a[4];
    int code_b[4];
    localparam logic [15:0][6:0] HEX_T = {7'h71, 7'h79, 7'h5e, 7'h39, 7'h7c, 7'h77, 7'h6f, 7'h7f,
        7'h07, 7'h7d, 7'h6d, 7'h66, 7'h4f, 7'h5b, 7'h06, 7'h3f};
    localparam logic [15:0][6:0] CODEB_T = {7'h00, 7'h73, 7'h38, 7'h76, 7'h79, 7'h40, 7'h6f, 7'h7f,
        7'h07, 7'h7d, 7'h6d, 7'h66, 7'h4f, 7'h5b, 7'h06, 7'h3f};
    wire logic hready = bsel ? ro_b : ro_a;

    sdd_link_if link_a ();
    sdd_link_if link_b ();
    sdd_host #(.EXT_BP_HALF_CYCLES(8)) sdd_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel_a),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(ro_a), .hrdata(rd_a), .hresp(resp_a), .link(link_a));
    sdd_device #(.MPU_VARIANT(1'b1), .OSC_DIV_CYCLES(4))
        sdd_device_inst (.hclk(hclk), .hresetn(hresetn), .link(link_a), .segment(seg_a), .backplane_master(bpm_a));
    sdd_host sdd_host_inst_b (.hclk(hclk), .hresetn(hresetn), .hsel(hsel_b),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(ro_b), .hrdata(rd_b), .hresp(resp_b), .link(link_b));
    sdd_device #(.LCD_VARIANT(1'b0), .HEX_DECODE(1'b0))
        sdd_device_inst_b (.hclk(hclk), .hresetn(hresetn), .link(link_b), .segment(seg_b), .backplane_master(bpm_b));
    sdd_link_checker sdd_link_checker_inst (.hclk(hclk), .hresetn(hresetn), .data_bits(link_a.data_bits),
        .digit_address(link_a.digit_address), .chip_select_n_first(link_a.chip_select_n_first),
        .chip_select_n_second(link_a.chip_select_n_second), .osc_drive_low(link_a.osc_drive_low),
        .bp_dev_out(link_a.bp_dev_out), .bp_dev_oe(link_a.bp_dev_oe));

    function automatic logic [27:0] lit(input bit b);
        logic [27:0] v;
        for (int d = 0; d < 4; d++) begin
            v[7*d +: 7] = b ? CODEB_T[code_b[d]] : HEX_T[code_a[d]];
        end
        return v;
    endfunction : lit

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic edge_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        if (hready !== 1'b1) begin
            miscompares++;
            complete_run();
        end
    endtask : edge_ready

    task automatic ahb(input bit b, input bit wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] r);
        bsel <= b;
        hsel_a <= !b;
        hsel_b <= b;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        edge_ready();
        htrans <= 2'h0;
        hsel_a <= 1'b0;
        hsel_b <= 1'b0;
        hwdata <= wd;
        edge_ready();
        r = b ? rd_b : rd_a;
        chk({31'h0, b ? resp_b : resp_a}, 32'h0000_0000);
    endtask : ahb

    task automatic wait_idle(input bit b);
        logic [31:0] r;
        int n;
        n = 0;
        do begin
            ahb(b, 1'b0, 8'h08, 32'h0000_0000, r);
            n++;
        end while (r[0] !== 1'b0 && n < 2000);
        if (r[0] !== 1'b0) begin
            miscompares++;
            complete_run();
        end
    endtask : wait_idle

    task automatic put(input bit b, input int dig, input int code);
        logic [31:0] r;
        wait_idle(b);
        ahb(b, 1'b1, 8'h04, 32'(dig * 16 + code), r);
        if (b) begin
            code_b[dig] = code;
        end else begin
            code_a[3 - dig] = code;
        end
        wait_idle(b);
    endtask : put

    // sample four cycles after a backplane edge, past the three-cycle settle, so the check never straddles one
    task automatic seg_a_chk();
        logic v;
        int n;
        v = link_a.backplane_terminal;
        n = 0;
        while (link_a.backplane_terminal === v && n < 600) begin
            @(negedge hclk);
            n++;
        end
        if (link_a.backplane_terminal === v) begin
            miscompares++;
            complete_run();
        end
        repeat (4) @(posedge hclk);
        chk({4'h0, seg_a}, {4'h0, lit(1'b0) ^ {28{link_a.backplane_terminal}}});
    endtask : seg_a_chk

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    initial begin
        logic [31:0] r;
        int off;
        int hi;
        hresetn = 1'b0;
        hsel_a = 1'b0;
        hsel_b = 1'b0;
        bsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        miscompares = 0;
        n_checks = 0;
        void'($urandom(13));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 1'b0, 8'h00, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        ahb(1'b0, 1'b0, 8'h0c, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        ahb(1'b0, 1'b1, 8'h00, 32'h0000_0001, r);
        ahb(1'b1, 1'b1, 8'h00, 32'h0000_0008, r);
        off = $urandom % 4;
        for (int i = 0; i < 16; i++) begin
            put(1'b0, (i + off) % 4, i);
            put(1'b1, i % 4, 15 - i);
            if (i >= 3) begin
                seg_a_chk();
                chk({4'h0, seg_b}, {4'h0, lit(1'b1)});
            end
        end
        ahb(1'b1, 1'b1, 8'h00, 32'h0000_0000, r);
        repeat (8) @(posedge hclk);
        chk({4'h0, seg_b}, 32'h0000_0000);
        // half duty: the pin is high for 128 of every 256 cycles
        ahb(1'b1, 1'b1, 8'h00, 32'h0000_8000, r);
        repeat (8) @(posedge hclk);
        hi = 0;
        repeat (256) begin
            @(negedge hclk);
            hi += (link_b.brightness === 1'b1) ? 1 : 0;
        end
        @(posedge hclk);
        chk(hi, 32'h0000_0080);
        ahb(1'b0, 1'b1, 8'h00, 32'h0000_0003, r);
        ahb(1'b0, 1'b1, 8'h00, 32'h0000_0001, r);
        repeat (20) @(posedge hclk);
        chk({31'h0, bpm_a}, 32'h0000_0001);
        ahb(1'b0, 1'b1, 8'h00, 32'h0000_0007, r);
        repeat (400) @(posedge hclk);
        chk({31'h0, bpm_a}, 32'h0000_0000);
        seg_a_chk();
        seg_a_chk();
        ahb(1'b0, 1'b1, 8'h00, 32'h0000_0001, r);
        repeat (20) @(posedge hclk);
        chk({31'h0, bpm_a}, 32'h0000_0001);
        seg_a_chk();
        complete_run();
    end
endmodule : four_digit_segment_decoder_driver_tb
